/* File: rtl/fsdi_regs.sv */
// Operation
// - mask word bit is one for each interface that may be switched off.
// - active word bit is one for each interface currently active.
// - bits 0-6 physical interfaces, 16-18 protocols, all others zero.
// - active word resets to ethernet plus tcp modbus, read only.
// - switchable mask is read only and resets to all zeros.
// - bit 0 of drive control enables command interface, reset value 01h.
// - software writes 32, 16, 8 bit set values and an 8 bit command.
// - switching object changes show up in the active word.
//
// Chosen here: register access over Avalon-MM.
module fsdi_regs #(
	parameter logic [31:0] SWITCHABLE_MASK = fsdi_pkg::FB_SWITCHABLE_RESET
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [fsdi_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic switch_load,
	input wire logic [31:0] switch_value,
	output logic [31:0] active_map,
	output logic drive_if_enable,
	output logic [31:0] drive_set_one,
	output logic [15:0] drive_set_two,
	output logic [7:0] drive_set_three,
	output logic [7:0] drive_command,
	output logic drive_command_strobe
);

	logic rst_n;
	fsdi_pkg::fsdi_bus_state_t state_ff;
	fsdi_pkg::fsdi_bus_state_t nxt_state;
	logic [31:0] readdata_ff;
	logic [7:0] ctrl_ff;
	logic [31:0] set_one_ff;
	logic [15:0] set_two_ff;
	logic [7:0] set_three_ff;
	logic [7:0] cmd_ff;
	logic cmd_strobe_ff;
	logic [31:0] map_value;

	// synchronised reset for the whole block
	fsdi_rst_sync u_rst_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.rst_sync_n(rst_n)
	);

	// active interface word holder
	fsdi_iface_map u_iface_map (
		.mclk(mclk),
		.rst_n(rst_n),
		.load(switch_load),
		.value(switch_value),
		.active_map(map_value)
	);

	// address split into object index and subindex
	wire [15:0] req_idx = avs_address[fsdi_pkg::ADDR_W-1:fsdi_pkg::IDX_LSB];
	wire [7:0] req_sub = avs_address[fsdi_pkg::IDX_LSB-1:fsdi_pkg::SUB_LSB];
	wire is_fb = req_idx == fsdi_pkg::FB_STATUS_IDX;
	wire is_ctrl = req_idx == fsdi_pkg::DRV_CTRL_IDX;
	wire is_input = req_idx == fsdi_pkg::DRV_INPUT_IDX;

	// per-entry decode
	wire hit_fb_count = is_fb && req_sub == fsdi_pkg::SUB_COUNT;
	wire hit_fb_mask = is_fb && req_sub == fsdi_pkg::SUB_ONE;
	wire hit_fb_active = is_fb && req_sub == fsdi_pkg::SUB_TWO;
	wire hit_ctrl = is_ctrl && req_sub == fsdi_pkg::SUB_COUNT;
	wire hit_in_count = is_input && req_sub == fsdi_pkg::SUB_COUNT;
	wire hit_set_one = is_input && req_sub == fsdi_pkg::SUB_ONE;
	wire hit_set_two = is_input && req_sub == fsdi_pkg::SUB_TWO;
	wire hit_set_three = is_input && req_sub == fsdi_pkg::SUB_THREE;
	wire hit_cmd = is_input && req_sub == fsdi_pkg::SUB_FOUR;

	// request handshake: one wait cycle, then answer
	wire req = avs_read || avs_write;
	wire answer = req && state_ff == fsdi_pkg::FSDI_ANSWER;
	wire wr_go = answer && avs_write;
	assign avs_waitrequest = req && state_ff == fsdi_pkg::FSDI_IDLE;

	// byte-lane merge of write data over the 32 and 16 bit set values
	logic [31:0] merged_one;
	logic [31:0] old_two;
	logic [31:0] merged_two;
	assign old_two = {16'h0000, set_two_ff};
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign merged_one[lane*8 +: 8] = avs_byteenable[lane] ?
				avs_writedata[lane*8 +: 8] : set_one_ff[lane*8 +: 8];
			assign merged_two[lane*8 +: 8] = avs_byteenable[lane] ?
				avs_writedata[lane*8 +: 8] : old_two[lane*8 +: 8];
		end
	endgenerate

	// write enables; read-only entries have none
	wire wr_ctrl = wr_go && hit_ctrl && avs_byteenable[0];
	wire wr_one = wr_go && hit_set_one;
	wire wr_two = wr_go && hit_set_two;
	wire wr_three = wr_go && hit_set_three && avs_byteenable[0];
	wire wr_cmd = wr_go && hit_cmd && avs_byteenable[0];

	// next values of the writable entries
	wire [7:0] nxt_ctrl = wr_ctrl ? avs_writedata[7:0] : ctrl_ff;
	wire [31:0] nxt_set_one = wr_one ? merged_one : set_one_ff;
	wire [15:0] nxt_set_two = wr_two ? merged_two[15:0] : set_two_ff;
	wire [7:0] nxt_set_three = wr_three ? avs_writedata[7:0] : set_three_ff;
	wire [7:0] nxt_cmd = wr_cmd ? avs_writedata[7:0] : cmd_ff;

	// read multiplexer, unmapped addresses read zero
	logic [31:0] nxt_readdata;
	always_comb begin
		nxt_readdata = 32'h00000000;
		if (hit_fb_count) begin
			nxt_readdata = {24'h000000, fsdi_pkg::FB_COUNT_RESET};
		end else if (hit_fb_mask) begin
			nxt_readdata = SWITCHABLE_MASK & fsdi_pkg::IFACE_USED_MASK;
		end else if (hit_fb_active) begin
			nxt_readdata = map_value;
		end else if (hit_ctrl) begin
			nxt_readdata = {24'h000000, ctrl_ff};
		end else if (hit_in_count) begin
			nxt_readdata = {24'h000000, fsdi_pkg::DRV_INPUT_COUNT_RESET};
		end else if (hit_set_one) begin
			nxt_readdata = set_one_ff;
		end else if (hit_set_two) begin
			nxt_readdata = {16'h0000, set_two_ff};
		end else if (hit_set_three) begin
			nxt_readdata = {24'h000000, set_three_ff};
		end else if (hit_cmd) begin
			nxt_readdata = {24'h000000, cmd_ff};
		end
	end

	// bus state: idle to answer while a request is held
	always_comb begin
		case (state_ff)
			fsdi_pkg::FSDI_IDLE: begin
				nxt_state = req ? fsdi_pkg::FSDI_ANSWER : fsdi_pkg::FSDI_IDLE;
			end
			fsdi_pkg::FSDI_ANSWER: begin
				nxt_state = fsdi_pkg::FSDI_IDLE;
			end
			default: begin
				nxt_state = fsdi_pkg::FSDI_IDLE;
			end
		endcase
	end

	// bus state and captured read data
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= fsdi_pkg::FSDI_IDLE;
			readdata_ff <= 32'h00000000;
		end else begin
			state_ff <= nxt_state;
			if (avs_waitrequest) begin
				readdata_ff <= nxt_readdata;
			end
		end
	end

	// drive interface control, enabled out of reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= fsdi_pkg::DRV_CTRL_RESET;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// set values and command byte
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			set_one_ff <= fsdi_pkg::DRV_SET_ONE_RESET;
			set_two_ff <= fsdi_pkg::DRV_SET_TWO_RESET;
			set_three_ff <= fsdi_pkg::DRV_SET_THREE_RESET;
			cmd_ff <= fsdi_pkg::DRV_CMD_RESET;
		end else begin
			set_one_ff <= nxt_set_one;
			set_two_ff <= nxt_set_two;
			set_three_ff <= nxt_set_three;
			cmd_ff <= nxt_cmd;
		end
	end

	// one-cycle pulse after each command write while enabled
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_strobe_ff <= 1'b0;
		end else begin
			cmd_strobe_ff <= wr_cmd && ctrl_ff[fsdi_pkg::DRV_ENABLE_BIT];
		end
	end

	// outputs
	assign avs_readdata = readdata_ff;
	assign active_map = map_value;
	assign drive_if_enable = ctrl_ff[fsdi_pkg::DRV_ENABLE_BIT];
	assign drive_set_one = set_one_ff;
	assign drive_set_two = set_two_ff;
	assign drive_set_three = set_three_ff;
	assign drive_command = cmd_ff;
	assign drive_command_strobe = cmd_strobe_ff;

endmodule : fsdi_regs

/* File: rtl/fsdi_pkg.sv */
package fsdi_pkg;

	// object indices (word address = {index, subindex})
	localparam logic [15:0] FB_STATUS_IDX = 16'h2103;
	localparam logic [15:0] DRV_CTRL_IDX = 16'h2290;
	localparam logic [15:0] DRV_INPUT_IDX = 16'h2291;

	// subindices
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_ONE = 8'h01;
	localparam logic [7:0] SUB_TWO = 8'h02;
	localparam logic [7:0] SUB_THREE = 8'h03;
	localparam logic [7:0] SUB_FOUR = 8'h04;

	// bus address layout
	localparam int ADDR_W = 26;
	localparam int IDX_LSB = 10;
	localparam int SUB_LSB = 2;

	// interface bit map positions
	localparam int USB_IFACE_BIT = 0;
	localparam int RS485_IFACE_BIT = 1;
	localparam int RS232_IFACE_BIT = 2;
	localparam int CAN_IFACE_BIT = 3;
	localparam int ETHERNET_IFACE_BIT = 4;
	localparam int REALTIME_ETHERNET_IFACE_BIT = 5;
	localparam int SPI_IFACE_BIT = 6;
	localparam int SERIAL_MODBUS_PROTOCOL_BIT = 16;
	localparam int TCP_MODBUS_PROTOCOL_BIT = 17;
	localparam int INDUSTRIAL_IP_PROTOCOL_BIT = 18;
	localparam logic [31:0] IFACE_USED_MASK = 32'h0007007F;

	// reset values
	localparam logic [7:0] FB_COUNT_RESET = 8'h02;
	localparam logic [31:0] FB_SWITCHABLE_RESET = 32'h00000000;
	localparam logic [31:0] FB_ACTIVE_RESET = 32'h00020010;
	localparam logic [7:0] DRV_CTRL_RESET = 8'h01;
	localparam logic [7:0] DRV_INPUT_COUNT_RESET = 8'h04;
	localparam logic [31:0] DRV_SET_ONE_RESET = 32'h00000000;
	localparam logic [15:0] DRV_SET_TWO_RESET = 16'h0000;
	localparam logic [7:0] DRV_SET_THREE_RESET = 8'h00;
	localparam logic [7:0] DRV_CMD_RESET = 8'h00;

	// drive interface control field
	localparam int DRV_ENABLE_BIT = 0;

	// bus answer state machine
	typedef enum logic {
		FSDI_IDLE = 1'b0,
		FSDI_ANSWER = 1'b1
	} fsdi_bus_state_t;

endpackage : fsdi_pkg

/* File: rtl/fsdi_rst_sync.sv */
module fsdi_rst_sync (
	input wire logic mclk,
	input wire logic reset_n,
	output logic rst_sync_n
);

	logic meta_ff;
	logic sync_ff;

	// asynchronous assert, release after two edges
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= 1'b1;
			sync_ff <= meta_ff;
		end
	end

	assign rst_sync_n = sync_ff;

endmodule : fsdi_rst_sync

/* File: rtl/fsdi_iface_map.sv */
module fsdi_iface_map (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [31:0] value,
	output logic [31:0] active_map
);

	logic [31:0] map_ff;
	logic [31:0] nxt_map;

	// switching object result, unused bits forced to zero
	assign nxt_map = load ? (value & fsdi_pkg::IFACE_USED_MASK) : map_ff;

	// active interface word, ethernet and tcp modbus after reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			map_ff <= fsdi_pkg::FB_ACTIVE_RESET;
		end else begin
			map_ff <= nxt_map;
		end
	end

	assign active_map = map_ff;

endmodule : fsdi_iface_map

/* File: tb/fsdi_regs_properties.sv */
module fsdi_regs_chk (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [25:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic switch_load,
	input wire logic [31:0] switch_value,
	input wire logic [31:0] active_map,
	input wire logic drive_if_enable,
	input wire logic [31:0] drive_set_one,
	input wire logic drive_command_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	// object address and accesses taken this cycle
	wire [23:0] obj = avs_address[25:2];
	wire wr_ok = avs_write && !avs_waitrequest;
	wire rd_ok = avs_read && !avs_waitrequest;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	chk_one_wait: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait");
	chk_map_unused: assert property (
		(active_map & ~32'h0007007F) == 32'h0)
		else $error("unused active bit set");
	chk_map_load: assert property (
		switch_load |=> active_map == ($past(switch_value) & 32'h0007007F))
		else $error("active word not loaded");
	chk_map_hold: assert property (!switch_load |=> $stable(active_map))
		else $error("active word changed without load");
	chk_enable_write: assert property (
		wr_ok && obj == 24'h229000 && avs_byteenable[0]
		|=> drive_if_enable == $past(avs_writedata[0]))
		else $error("enable bit not written");
	chk_set_one: assert property (
		wr_ok && obj == 24'h229101 && avs_byteenable == 4'hF
		|=> drive_set_one == $past(avs_writedata))
		else $error("set value one not written");
	chk_strobe_cause: assert property (
		drive_command_strobe |-> $past(wr_ok && obj == 24'h229104
		&& drive_if_enable))
		else $error("strobe without enabled command write");
	chk_mask_read: assert property (
		rd_ok && obj == 24'h210301 |-> avs_readdata == 32'h0)
		else $error("mask not zero");
	chk_active_read: assert property (
		rd_ok && obj == 24'h210302 |-> avs_readdata == active_map)
		else $error("active word read differs");
	cover property (drive_command_strobe);
	cover property (switch_load);
	cover property (rd_ok && obj == 24'h210302);
endmodule : fsdi_regs_chk

bind fsdi_regs fsdi_regs_chk u_chk (.mclk, .reset_n, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
	.avs_waitrequest, .switch_load, .switch_value, .active_map,
	.drive_if_enable, .drive_set_one, .drive_command_strobe);

/* File: tb/fieldbus_status_and_drive_iface_objects_tb.sv */
module fieldbus_status_and_drive_iface_objects_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [25:0] avs_address = 26'h0;
	logic [31:0] avs_writedata = 32'h0, switch_value = 32'h0, avs_readdata;
	logic [3:0] avs_byteenable = 4'hF;
	logic switch_load = 1'b0, avs_waitrequest, drive_if_enable;
	logic drive_command_strobe;
	logic [31:0] drive_set_one, active_map, rd, v, seed = 32'h3552;
	logic [15:0] drive_set_two;
	logic [7:0] drive_set_three, drive_command;
	logic [31:0] e [4];
	int n_errors = 0, comparisons = 0;
	// unmapped, read-only entries, control, then the four drive inputs
	logic [23:0] objs [10] = '{24'h123456, 24'h210300, 24'h210301,
		24'h210302, 24'h229100, 24'h229000, 24'h229101, 24'h229102,
		24'h229103, 24'h229104};
	logic [31:0] dflt [10] = '{32'h0, 32'h02, 32'h0, 32'h00020010, 32'h04,
		32'h01, 32'h0, 32'h0, 32'h0, 32'h0};
	fsdi_regs dut (.mclk, .reset_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.switch_load, .switch_value, .active_map, .drive_if_enable,
		.drive_set_one, .drive_set_two, .drive_set_three, .drive_command,
		.drive_command_strobe);
	initial forever #5 mclk = ~mclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// entry width by subindex
	function automatic logic [31:0] wmask(input logic [7:0] sub);
		return sub == 8'h01 ? 32'hFFFFFFFF
			: sub == 8'h02 ? 32'h0000FFFF : 32'h000000FF;
	endfunction : wmask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	// one access, returns at the edge that completes it
	task automatic acc(input logic wr, input logic [23:0] o,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge mclk);
		avs_address <= {o, 2'b00};
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= !wr;
		avs_write <= wr;
		// wait states end at the edge that sees waitrequest low
		@(posedge mclk);
		while (avs_waitrequest) begin
			@(posedge mclk);
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : acc
	// reset pulse then every entry at its reset value
	task automatic reset_check;
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		for (int i = 0; i < 10; i++) begin
			acc(0, objs[i], 32'h0, 4'hF);
			chk(rd, dflt[i]);
		end
		chk(drive_if_enable, 1'b1);
	endtask : reset_check
	initial begin
		#100000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		reset_check();
		// writes to read-only and unmapped places are dropped
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			acc(1, objs[i], seed, 4'hF);
			acc(0, objs[i], 32'h0, 4'hF);
			chk(rd, dflt[i]);
		end
		// random drive inputs, command strobe while enabled
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			e[i % 4] = seed & wmask(objs[6 + i % 4][7:0]);
			acc(1, objs[6 + i % 4], seed, 4'hF);
			if (i % 4 == 3) begin
				@(negedge mclk);
				chk(drive_command_strobe, 1'b1);
			end
			acc(0, objs[6 + i % 4], 32'h0, 4'hF);
			chk(rd, e[i % 4]);
		end
		acc(1, 24'h229104, ~e[3], 4'hE);
		@(negedge mclk);
		chk(drive_set_one, e[0]);
		chk(drive_set_two, e[1]);
		chk(drive_set_three, e[2]);
		chk(drive_command, e[3]);
		// interface off: command stored but not strobed
		acc(1, 24'h229000, 32'hFE, 4'hF);
		@(negedge mclk);
		chk(drive_if_enable, 1'b0);
		acc(0, 24'h229000, 32'h0, 4'hF);
		chk(rd, 32'hFE);
		acc(1, 24'h229104, 32'h5A, 4'hF);
		@(negedge mclk);
		chk(drive_command_strobe, 1'b0);
		chk(drive_command, 32'h5A);
		// switching object loads, first with every bit set
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			v = i == 0 ? 32'hFFFFFFFF : seed;
			@(posedge mclk);
			switch_load <= 1'b1;
			switch_value <= v;
			@(posedge mclk);
			switch_load <= 1'b0;
			acc(0, 24'h210302, 32'h0, 4'hF);
			chk(rd, v & 32'h0007007F);
			chk(active_map, v & 32'h0007007F);
		end
		reset_check();
		report_and_stop();
	end
endmodule : fieldbus_status_and_drive_iface_objects_tb
